// *** hw/flash_region_decode.sv ***
// section and region decoding for one flash word address
`timescale 1ns/1ps
`default_nettype none
module flash_region_decode (
    input wire logic [16:0] addr,
    input wire logic [1:0] bootSize,
    output logic inBoot,
    output logic inNrww,
    output logic [16:0] bootStart
);
    // boundary taken from the size fuses
    always_comb begin
        unique case (bootSize)
            2'h0: bootStart = flash_rww_pkg::BOOT_START_0;
            2'h1: bootStart = flash_rww_pkg::BOOT_START_1;
            2'h2: bootStart = flash_rww_pkg::BOOT_START_2;
            2'h3: bootStart = flash_rww_pkg::BOOT_START_3;
        endcase
        inBoot = (addr >= bootStart);
        inNrww = (addr >= flash_rww_pkg::NO_READ_WHILE_WRITE_REGION_START);
    end
endmodule : flash_region_decode
`default_nettype wire

// *** hw/flash_rww_ctrl.sv ***
// self-programming controller: section gating, locks, stall and busy flag
// Functional notes
// - Programming starts only when the store op is fetched from the boot section.
// - Store op executed from the application section is ignored.
// - From the boot section, any flash address may be programmed.
// - Application/boot boundary comes from the boot size fuses.
// - Application section protection comes from the application lock set.
// - Boot section protection comes from the separate boot lock set.
// - Flash splits into fixed read-while-write and no-read-while-write regions.
// - Programming the rww region leaves no_read_while_write_region reads served, CPU running.
// - Programming the no_read_while_write_region region halts the CPU for the whole operation.
// - During programming, reads of the rww region return no valid code.
// - Every boot section size lies inside the no_read_while_write_region region.
// - Rww busy bit reads one while the rww region is blocked.
// - Busy bit stays set after completion until software clears it.
// - Pages are programmed whole; page layout does not affect reads.
// - Application lock pair: 11 free, 10 no store, 00 both, 01 no boot reads; only the store part is enforced, reads are never restricted.
// - Boot lock bits are programmed by software, cleared only by chip erase.
// - Reset vector is 0x0000 unless boot reset fuse is programmed.
//
// Register access over AXI4-Lite and the placing of the registers were decided locally.
`timescale 1ns/1ps
`default_nettype none
module flash_rww_ctrl (
    input wire logic clk,
    input wire logic resetn,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [16:0] fetchAddr,
    input wire logic [16:0] readAddr,
    output logic cpuHalt,
    output logic readBlocked,
    output logic [16:0] resetVector
);
    typedef enum logic {IDLE, PROG} prog_e;
    localparam logic [15:0] OP_CYC = 16'(flash_rww_pkg::PAGE_OP_CYC);

    // bus state
    logic awHeld_q, awHeld_d, wHeld_q, wHeld_d, bValid_q, bValid_d;
    logic awReady_q, awReady_d, wReady_q, wReady_d;
    logic [7:0] awAddr_q, awAddr_d;
    logic [31:0] wData_q, wData_d;
    logic arReady_q, arReady_d, rValid_q, rValid_d;
    logic [31:0] rData_q, rData_d;
    logic [1:0] rResp_q, rResp_d, bResp_q, bResp_d;
    // controller state
    prog_e state_q, state_d;
    logic [15:0] cnt_q, cnt_d;
    logic [16:0] target_q, target_d;
    logic targetNrww_q, targetNrww_d;
    logic rwwBusy_q, rwwBusy_d;
    logic reject_q, reject_d;
    logic [3:0] lock_q, lock_d;
    logic [2:0] fuse_q, fuse_d;
    logic halt_q, halt_d, blocked_q, blocked_d;
    logic [16:0] resetVec_q, resetVec_d;
    logic fuseLoaded_q, fuseLoaded_d;

    logic fetchBoot, fetchNrww, tgtBoot, tgtNrww, rdBoot, rdNrww;
    logic [16:0] bootStartF;
    logic doWrite, wrAllowed;
    logic [7:0] wrAddr;
    logic [31:0] wrData;

    flash_region_decode u_fetch (.addr(fetchAddr), .bootSize(fuse_q[1:0]),
        .inBoot(fetchBoot), .inNrww(fetchNrww), .bootStart(bootStartF));
    flash_region_decode u_tgt (.addr(target_q), .bootSize(fuse_q[1:0]),
        .inBoot(tgtBoot), .inNrww(tgtNrww), .bootStart());
    flash_region_decode u_read (.addr(readAddr), .bootSize(fuse_q[1:0]),
        .inBoot(rdBoot), .inNrww(rdNrww), .bootStart());

    // store op allowed to write the target under the lock pairs
    function automatic logic storeAllowed(input logic [3:0] lk, input logic tBoot);
        logic [1:0] pair;
        pair = tBoot ? lk[flash_rww_pkg::LOCK_BOOT_LSB +: 2] : lk[flash_rww_pkg::LOCK_APP_LSB +: 2];
        storeAllowed = pair[0]; // low bit set in modes 11 and 01, which leave store free
    endfunction : storeAllowed

    // write channel: take address and data in either order
    always_comb begin
        awHeld_d = awHeld_q;
        wHeld_d = wHeld_q;
        awAddr_d = awAddr_q;
        wData_d = wData_q;
        bValid_d = bValid_q;
        bResp_d = bResp_q;
        if (s_axi_awvalid && awReady_q) begin
            awHeld_d = 1'b1;
            awAddr_d = s_axi_awaddr;
        end
        if (s_axi_wvalid && wReady_q) begin
            wHeld_d = 1'b1;
            wData_d = s_axi_wdata;
        end
        if (bValid_q && s_axi_bready) begin
            bValid_d = 1'b0;
        end else if (awHeld_q && wHeld_q) begin
            awHeld_d = 1'b0;
            wHeld_d = 1'b0;
            bValid_d = 1'b1;
            bResp_d = wrAllowed ? flash_rww_pkg::RESP_OKAY : flash_rww_pkg::RESP_SLVERR;
        end
        // readies offered ahead of valid while nothing is held
        awReady_d = !awHeld_d && !bValid_d;
        wReady_d = !wHeld_d && !bValid_d;
    end
    assign doWrite = awHeld_q && wHeld_q && !bValid_q;
    assign wrAddr = awAddr_q;
    assign wrData = wData_q;
    assign wrAllowed = (wrAddr == flash_rww_pkg::OFF_CTRL) || (wrAddr == flash_rww_pkg::OFF_ADDR)
        || (wrAddr == flash_rww_pkg::OFF_LOCK) || (wrAddr == flash_rww_pkg::OFF_FUSE);

    // read channel, one cycle after address
    always_comb begin
        arReady_d = 1'b0;
        rValid_d = rValid_q;
        rData_d = rData_q;
        rResp_d = rResp_q;
        if (rValid_q && s_axi_rready) begin
            rValid_d = 1'b0;
        end else if (s_axi_arvalid && !rValid_q && !arReady_q) begin
            arReady_d = 1'b1;
            rValid_d = 1'b1;
            rResp_d = flash_rww_pkg::RESP_OKAY;
            unique case (s_axi_araddr)
                flash_rww_pkg::OFF_STATUS: rData_d = {28'h0000000, reject_q, halt_q,
                    rwwBusy_q, state_q == PROG};
                flash_rww_pkg::OFF_ADDR: rData_d = {15'h0000, target_q};
                flash_rww_pkg::OFF_LOCK: rData_d = {28'h0000000, lock_q};
                flash_rww_pkg::OFF_FUSE: rData_d = {29'h0000000, fuse_q};
                flash_rww_pkg::OFF_CTRL: rData_d = 32'h00000000;
                default: begin
                    rData_d = 32'h00000000;
                    rResp_d = flash_rww_pkg::RESP_SLVERR;
                end
            endcase
        end
    end

    // programming sequencer, locks and busy flag
    always_comb begin
        logic startOp, rwwClear;
        startOp = 1'b0;
        rwwClear = 1'b0;
        state_d = state_q;
        cnt_d = cnt_q;
        target_d = target_q;
        targetNrww_d = targetNrww_q;
        rwwBusy_d = rwwBusy_q;
        reject_d = reject_q;
        lock_d = lock_q;
        fuse_d = fuse_q;
        fuseLoaded_d = 1'b1;
        resetVec_d = resetVec_q;
        if (doWrite && wrAddr == flash_rww_pkg::OFF_ADDR && state_q == IDLE) begin
            // page aligned; page layout never touches the read path
            target_d = {wrData[16:flash_rww_pkg::PAGE_WORDS_LOG2],
                {flash_rww_pkg::PAGE_WORDS_LOG2{1'b0}}};
        end
        if (doWrite && wrAddr == flash_rww_pkg::OFF_FUSE && state_q == IDLE) begin
            fuse_d = wrData[2:0];
            fuseLoaded_d = 1'b0; // reset vector follows the new fuses
        end
        if (doWrite && wrAddr == flash_rww_pkg::OFF_LOCK) begin
            lock_d = lock_q & wrData[3:0];
        end
        if (doWrite && wrAddr == flash_rww_pkg::OFF_CTRL) begin
            if (wrData[flash_rww_pkg::CTRL_CHIPERASE_BIT] && state_q == IDLE) begin
                lock_d = flash_rww_pkg::LOCK_RESET;
            end
            rwwClear = wrData[flash_rww_pkg::CTRL_RWWCLR_BIT] && state_q == IDLE;
            if ((wrData[flash_rww_pkg::CTRL_ERASE_BIT] || wrData[flash_rww_pkg::CTRL_WRITE_BIT])
                && state_q == IDLE) begin
                if (fetchBoot && storeAllowed(lock_q, tgtBoot)) begin
                    startOp = 1'b1;
                    reject_d = 1'b0;
                end else begin
                    reject_d = 1'b1;
                end
            end
        end
        if (rwwClear) begin
            rwwBusy_d = 1'b0;
        end
        unique case (state_q)
            IDLE: if (startOp) begin
                state_d = PROG;
                cnt_d = OP_CYC;
                targetNrww_d = tgtNrww;
                if (!tgtNrww) begin
                    rwwBusy_d = 1'b1;
                end
            end
            PROG: begin
                if (cnt_q == 16'h0001) begin
                    state_d = IDLE; // busy flag left for software
                end
                cnt_d = cnt_q - 16'h0001;
            end
        endcase
        if (!fuseLoaded_q) begin
            resetVec_d = fuse_q[flash_rww_pkg::FUSE_BOOT_RESET_VECTOR_FUSE_BIT] ? flash_rww_pkg::APP_RESET_VEC
                : bootStartF;
        end
    end

    // stall and read blocking outputs
    always_comb begin
        halt_d = (state_d == PROG) && targetNrww_d;
        blocked_d = rwwBusy_d && !rdNrww;
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            awHeld_q <= 1'b0;
            wHeld_q <= 1'b0;
            awAddr_q <= 8'h00;
            wData_q <= 32'h00000000;
            bValid_q <= 1'b0;
            awReady_q <= 1'b0;
            wReady_q <= 1'b0;
            bResp_q <= 2'h0;
            arReady_q <= 1'b0;
            rValid_q <= 1'b0;
            rData_q <= 32'h00000000;
            rResp_q <= 2'h0;
            state_q <= IDLE;
            cnt_q <= 16'h0000;
            target_q <= 17'h00000;
            targetNrww_q <= 1'b0;
            rwwBusy_q <= 1'b0;
            reject_q <= 1'b0;
            lock_q <= flash_rww_pkg::LOCK_RESET;
            fuse_q <= 3'h7;
            halt_q <= 1'b0;
            blocked_q <= 1'b0;
            resetVec_q <= 17'h00000;
            fuseLoaded_q <= 1'b0;
        end else begin
            awHeld_q <= awHeld_d;
            wHeld_q <= wHeld_d;
            awAddr_q <= awAddr_d;
            wData_q <= wData_d;
            bValid_q <= bValid_d;
            awReady_q <= awReady_d;
            wReady_q <= wReady_d;
            bResp_q <= bResp_d;
            arReady_q <= arReady_d;
            rValid_q <= rValid_d;
            rData_q <= rData_d;
            rResp_q <= rResp_d;
            state_q <= state_d;
            cnt_q <= cnt_d;
            target_q <= target_d;
            targetNrww_q <= targetNrww_d;
            rwwBusy_q <= rwwBusy_d;
            reject_q <= reject_d;
            lock_q <= lock_d;
            fuse_q <= fuse_d;
            halt_q <= halt_d;
            blocked_q <= blocked_d;
            resetVec_q <= resetVec_d;
            fuseLoaded_q <= fuseLoaded_d;
        end
    end

    // outputs straight from flip-flops
    assign s_axi_awready = awReady_q;
    assign s_axi_wready = wReady_q;
    assign s_axi_bvalid = bValid_q;
    assign s_axi_bresp = bResp_q;
    assign s_axi_arready = arReady_q;
    assign s_axi_rvalid = rValid_q;
    assign s_axi_rdata = rData_q;
    assign s_axi_rresp = rResp_q;
    assign cpuHalt = halt_q;
    assign readBlocked = blocked_q;
    assign resetVector = resetVec_q;

    sequence s_rwwStart;
        state_q == IDLE && state_d == PROG && !targetNrww_d;
    endsequence
    a_rww_busy_set: assert property (@(posedge clk) disable iff (!resetn)
        s_rwwStart |=> rwwBusy_q) else $error("rww busy not set at start");
    a_busy_sticky: assert property (@(posedge clk) disable iff (!resetn)
        rwwBusy_q && !(doWrite && wrAddr == flash_rww_pkg::OFF_CTRL) |=> rwwBusy_q)
        else $error("rww busy dropped without clear");
    a_app_no_start: assert property (@(posedge clk) disable iff (!resetn)
        state_q == IDLE && !fetchBoot |=> state_q == IDLE) else $error("start from app section");
    a_no_read_while_write_region_halt: assert property (@(posedge clk) disable iff (!resetn)
        state_q == PROG && targetNrww_q |-> cpuHalt) else $error("no halt on no_read_while_write_region op");
    a_rww_no_halt: assert property (@(posedge clk) disable iff (!resetn)
        state_q == PROG && !targetNrww_q |-> !cpuHalt) else $error("halt on rww op");
    a_rww_blocked: assert property (@(posedge clk) disable iff (!resetn)
        rwwBusy_q && !rdNrww |=> readBlocked || !rwwBusy_q || rdNrww) else $error("rww read not blocked");
    a_status_busy: assert property (@(posedge clk) disable iff (!resetn)
        rValid_d && !rValid_q && s_axi_araddr == flash_rww_pkg::OFF_STATUS
        |=> rData_q[flash_rww_pkg::ST_RWWBUSY_BIT] == $past(rwwBusy_q)) else $error("status busy wrong");
    a_boot_lock_keep: assert property (@(posedge clk) disable iff (!resetn)
        !(doWrite && wrAddr == flash_rww_pkg::OFF_CTRL) |=> (lock_q & ~$past(lock_q)) == 4'h0)
        else $error("lock bit cleared without chip erase");
endmodule : flash_rww_ctrl
`default_nettype wire

// *** hw/flash_rww_pkg.sv ***
// shared constants for the flash self-programming controller
package flash_rww_pkg;
    // word address width of the program flash
    localparam int ADDR_W = 17;
    // register byte offsets
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_STATUS = 8'h04;
    localparam logic [7:0] OFF_ADDR = 8'h08;
    localparam logic [7:0] OFF_LOCK = 8'h0C;
    localparam logic [7:0] OFF_FUSE = 8'h10;
    // control fields
    localparam int CTRL_ERASE_BIT = 0;
    localparam int CTRL_WRITE_BIT = 1;
    localparam int CTRL_RWWCLR_BIT = 2;
    localparam int CTRL_CHIPERASE_BIT = 3;
    // status fields
    localparam int ST_BUSY_BIT = 0;
    localparam int ST_RWWBUSY_BIT = 1;
    localparam int ST_HALT_BIT = 2;
    localparam int ST_REJECT_BIT = 3;
    // lock fields: app pair at [1:0], boot pair at [3:2]
    localparam int LOCK_APP_LSB = 0;
    localparam int LOCK_BOOT_LSB = 2;
    localparam logic [3:0] LOCK_RESET = 4'hF;
    // fuse fields: boot size [1:0], boot reset vector [2]
    localparam int FUSE_SIZE_LSB = 0;
    localparam int FUSE_BOOT_RESET_VECTOR_FUSE_BIT = 2;
    // fixed start of the no-read-while-write region (word address)
    localparam logic [16:0] NO_READ_WHILE_WRITE_REGION_START = 17'h1F000;
    // boot section starts per size code 0..3; all inside the no-read-while-write region
    localparam logic [16:0] BOOT_START_0 = 17'h1F000;
    localparam logic [16:0] BOOT_START_1 = 17'h1F800;
    localparam logic [16:0] BOOT_START_2 = 17'h1FC00;
    localparam logic [16:0] BOOT_START_3 = 17'h1FE00;
    localparam logic [16:0] APP_RESET_VEC = 17'h00000;
    // page operation time and cycles at 40 MHz
    localparam int PAGE_OP_NS = 4500;
    localparam int CLK_NS = 25;
    localparam int PAGE_OP_CYC = (PAGE_OP_NS + CLK_NS - 1) / CLK_NS;
    localparam int PAGE_WORDS_LOG2 = 7;
    // bus response codes
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : flash_rww_pkg

// *** tb/cpu_core_model.sv ***
// behavioural core model: supplies fetch and read addresses to the controller
`timescale 1ns/1ps
`default_nettype none
module cpu_core_model (
    input wire logic clk,
    input wire logic resetn,
    input wire logic cpuHalt,
    input wire logic [16:0] reqFetch,
    input wire logic [16:0] reqRead,
    output logic [16:0] fetchAddr,
    output logic [16:0] readAddr
);
    // a halted core holds its addresses; no interrupt vectoring is modelled
    // rww reads happen only where the bench asks for them
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            fetchAddr <= 17'h00000;
            readAddr <= 17'h00000;
        end else if (!cpuHalt) begin
            fetchAddr <= reqFetch;
            readAddr <= reqRead;
        end
    end
endmodule : cpu_core_model
`default_nettype wire

// *** tb/tb_top.sv ***
// self-checking bench for the flash self-programming controller
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic clk, resetn, awvalid, wvalid, bready, arvalid, rready;
    logic awready, wready, bvalid, arready, rvalid, cpuHalt, readBlocked;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, rdata, st;
    logic [1:0] bresp, rresp, rsp;
    logic [16:0] fetchAddr, readAddr, reqFetch, reqRead, resetVector, tgt;
    int miscompares = 0, testsRun = 0, cycles = 0, n;
    flash_rww_ctrl u_dut (.clk(clk), .resetn(resetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .fetchAddr(fetchAddr),
        .readAddr(readAddr), .cpuHalt(cpuHalt), .readBlocked(readBlocked), .resetVector(resetVector));
    cpu_core_model u_cpu (.clk(clk), .resetn(resetn), .cpuHalt(cpuHalt), .reqFetch(reqFetch),
        .reqRead(reqRead), .fetchAddr(fetchAddr), .readAddr(readAddr));
    // clock generation, 25 ns period
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    // hang guard
    always @(posedge clk) begin
        cycles++;
        if (cycles == 60000) begin
            miscompares++;
            give_verdict();
        end
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        testsRun++;
        if (seen !== exp) begin
            miscompares++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", testsRun, miscompares);
        if (miscompares == 0 && testsRun > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : give_verdict
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        logic awDone, wDone;
        awDone = 1'b0;
        wDone = 1'b0;
        @(posedge clk);
        awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
        while (!(awDone && wDone)) begin
            @(posedge clk);
            if (awready === 1'b1 && !awDone) begin awDone = 1'b1; awvalid <= 1'b0; end
            if (wready === 1'b1 && !wDone) begin wDone = 1'b1; wvalid <= 1'b0; end
        end
        do @(posedge clk); while (bvalid !== 1'b1);
        r = bresp;
        bready <= 1'b0;
    endtask : axi_wr
    task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge clk);
        araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
        do begin
            @(posedge clk);
            if (arready === 1'b1) arvalid <= 1'b0;
        end while (rvalid !== 1'b1);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask : axi_rd
    // program one page: set fetch location, target, then the start command
    task automatic page_op(input logic [16:0] f, input logic [16:0] t, input int b);
        reqFetch <= f;
        axi_wr(flash_rww_pkg::OFF_ADDR, {15'h0, t}, rsp);
        axi_wr(flash_rww_pkg::OFF_CTRL, 32'h1 << b, rsp);
        axi_rd(flash_rww_pkg::OFF_STATUS, st, rsp);
    endtask : page_op
    task automatic wait_idle();
        do axi_rd(flash_rww_pkg::OFF_STATUS, st, rsp); while (st[flash_rww_pkg::ST_BUSY_BIT] !== 1'b0);
    endtask : wait_idle
    // expected boot start per size code
    function automatic logic [16:0] boot_start(input int k);
        return k == 0 ? flash_rww_pkg::BOOT_START_0 : k == 1 ? flash_rww_pkg::BOOT_START_1 :
               k == 2 ? flash_rww_pkg::BOOT_START_2 : flash_rww_pkg::BOOT_START_3;
    endfunction : boot_start
    // main sequence
    initial begin
        n = $urandom(37576);
        resetn = 1'b0; awvalid = 1'b0; wvalid = 1'b0; bready = 1'b0; arvalid = 1'b0; rready = 1'b0;
        awaddr = 8'h00; araddr = 8'h00; wdata = 32'h0; reqFetch = 17'h0; reqRead = 17'h0;
        repeat (5) @(posedge clk);
        resetn <= 1'b1;
        axi_rd(flash_rww_pkg::OFF_LOCK, st, rsp);
        chk(st, 32'hF);
        axi_rd(flash_rww_pkg::OFF_FUSE, st, rsp);
        chk(st, 32'h7);
        chk(resetVector, flash_rww_pkg::APP_RESET_VEC);
        axi_rd(8'h14, st, rsp);
        chk(rsp, flash_rww_pkg::RESP_SLVERR);
        axi_wr(flash_rww_pkg::OFF_STATUS, 32'h0, rsp);
        chk(rsp, flash_rww_pkg::RESP_SLVERR);
        $display("test reset done");
        // store op from the application section is refused
        page_op({16'($urandom_range(0, 16'hF000)), 1'b0}, 17'h00080, flash_rww_pkg::CTRL_WRITE_BIT);
        chk(st[flash_rww_pkg::ST_REJECT_BIT], 1'b1);
        chk(st[flash_rww_pkg::ST_BUSY_BIT], 1'b0);
        $display("test app gating done");
        // rww page op: core keeps running, rww reads blocked, flag sticky
        tgt = {10'($urandom_range(0, 10'h1DF)), 7'h00};
        page_op(flash_rww_pkg::BOOT_START_3, tgt, flash_rww_pkg::CTRL_ERASE_BIT);
        chk(st[2:0], 3'b011);
        chk(cpuHalt, 1'b0);
        reqRead <= {16'($urandom_range(0, 16'hF7FF)), 1'b0};
        repeat (3) @(posedge clk);
        chk(readBlocked, 1'b1);
        reqRead <= flash_rww_pkg::NO_READ_WHILE_WRITE_REGION_START + 17'($urandom_range(0, 12'hFFF));
        repeat (3) @(posedge clk);
        chk(readBlocked, 1'b0);
        wait_idle();
        chk(st[flash_rww_pkg::ST_RWWBUSY_BIT], 1'b1);
        axi_wr(flash_rww_pkg::OFF_CTRL, 32'h1 << flash_rww_pkg::CTRL_RWWCLR_BIT, rsp);
        axi_rd(flash_rww_pkg::OFF_STATUS, st, rsp);
        chk(st[flash_rww_pkg::ST_RWWBUSY_BIT], 1'b0);
        $display("test rww op done");
        // no_read_while_write_region page op in the boot section itself halts the core for the op time
        page_op(flash_rww_pkg::BOOT_START_3, flash_rww_pkg::BOOT_START_3, flash_rww_pkg::CTRL_WRITE_BIT);
        chk(st[2:0], 3'b101);
        n = 0;
        while (cpuHalt === 1'b1) begin @(posedge clk); n++; end
        chk(n >= flash_rww_pkg::PAGE_OP_CYC - 8 && n <= flash_rww_pkg::PAGE_OP_CYC, 1'b1);
        wait_idle();
        $display("test no_read_while_write_region op done");
        // lock sets: app pair, then boot pair, writes only program, chip erase clears
        axi_wr(flash_rww_pkg::OFF_LOCK, 32'hE, rsp);
        page_op(flash_rww_pkg::BOOT_START_3, 17'h00100, flash_rww_pkg::CTRL_WRITE_BIT);
        chk(st[flash_rww_pkg::ST_REJECT_BIT], 1'b1);
        page_op(flash_rww_pkg::BOOT_START_3, flash_rww_pkg::BOOT_START_3, flash_rww_pkg::CTRL_ERASE_BIT);
        chk(st[flash_rww_pkg::ST_BUSY_BIT], 1'b1);
        wait_idle();
        axi_wr(flash_rww_pkg::OFF_LOCK, 32'hB, rsp);
        axi_rd(flash_rww_pkg::OFF_LOCK, st, rsp);
        chk(st, 32'hA);
        page_op(flash_rww_pkg::BOOT_START_3, flash_rww_pkg::BOOT_START_3, flash_rww_pkg::CTRL_ERASE_BIT);
        chk(st[flash_rww_pkg::ST_REJECT_BIT], 1'b1);
        axi_wr(flash_rww_pkg::OFF_CTRL, 32'h1 << flash_rww_pkg::CTRL_CHIPERASE_BIT, rsp);
        axi_rd(flash_rww_pkg::OFF_LOCK, st, rsp);
        chk(st, 32'hF);
        $display("test locks done");
        // every boot size: boundary from fuses, boot section inside no_read_while_write_region
        for (int k = 0; k < 4; k++) begin
            // boot reset fuse programmed: reset vector moves to the boot start
            axi_wr(flash_rww_pkg::OFF_FUSE, 32'(k), rsp);
            page_op(boot_start(k) - 17'h1, boot_start(k), flash_rww_pkg::CTRL_WRITE_BIT);
            chk(st[flash_rww_pkg::ST_REJECT_BIT], 1'b1);
            chk(resetVector, boot_start(k));
            page_op(boot_start(k), boot_start(k), flash_rww_pkg::CTRL_WRITE_BIT);
            chk(st[2:0], 3'b101);
            wait_idle();
        end
        $display("test boot sizes done");
        give_verdict();
    end
endmodule : tb_top
`default_nettype wire
